//--- rtl/plt_defs.svh
/*
 * Constants for the pixel level trim and dummy row block: register
 * addresses, field positions, reset values and datapath figures.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef PLT_DEFS_SVH
`define PLT_DEFS_SVH

// ****************************************************************
// Register addresses (8-bit register port)
// ****************************************************************
`define PLT_ADDR_XFER_SYNC 8'h29
`define PLT_ADDR_OFS_LO 8'h64
`define PLT_ADDR_OFS_HI 8'h65
`define PLT_ADDR_COL_GAIN 8'h66
`define PLT_ADDR_RAMP 8'h67
`define PLT_ADDR_DUMMY 8'h76
`define PLT_ADDR_EXTRA 8'h79

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PLT_BIT_XFER_SYNC 2
`define PLT_BIT_GAIN_DBL 0
`define PLT_BIT_BLACK_EN 1
`define PLT_RST_OFS 14'h3FC3
`define PLT_RST_RAMP 8'h20
`define PLT_RST_DUMMY 8'h00

// ****************************************************************
// Datapath figures
// ****************************************************************
`define PLT_ADC_OFFSET 16'sh0046
`define PLT_CODE_MAX 16'sh0FFF
`define PLT_CODE_MIN 16'sh0000
`define PLT_BLACK_COLS 12'h010
`define PLT_FIFO_DEPTH 8
`define PLT_PIX_W 12

`endif

//--- rtl/plt_pkg.sv
/*
 * Types shared by the pixel level trim block.
 * Assumes plt_defs.svh is available on the include path.
 */
package plt_pkg;
  // Sequencer states
  typedef enum logic [1:0] {
    PLT_IDLE  = 2'b00,
    PLT_ROW   = 2'b01,
    PLT_DUMMY = 2'b10
  } plt_state_t;
  // Column gain factor in tenths
  typedef logic [5:0] plt_gain_t;
endpackage

//--- rtl/plt_fifo.sv
/*
 * Small flop FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module plt_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage
  logic [AW-1:0] wr_ff;  // Write index
  logic [AW-1:0] rd_ff;  // Read index
  logic [AW:0] cnt_ff;  // Fill level
  logic push;
  logic pop;

  assign o_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign o_valid = (cnt_ff != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem_ff[rd_ff];

  // Entry write, one flop row per entry
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge i_clock) begin
      if (push && wr_ff == AW'(g)) begin
        mem_ff[g] <= i_data;
      end
    end
  end

  // Pointers and level
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // plt_fifo

//--- rtl/plt_gain.sv
/*
 * Column gain factor decode, in tenths of unity.
 * Assumes a purely combinational context.
 */
`timescale 1ns/1ps
module plt_gain
  import plt_pkg::*;
(
  input wire logic [1:0] i_code,
  input wire logic i_double,
  output plt_gain_t o_gain
);
  plt_gain_t base;
  // Code to x1.0, x1.2, x1.4, x1.6; doubled when asked
  always_comb begin
    case (i_code)
      2'h0: base = 6'h0A;
      2'h1: base = 6'h0C;
      2'h2: base = 6'h0E;
      default: base = 6'h10;
    endcase
    // Six bits hold the doubled x1.6 setting (32 tenths) without loss
    o_gain = i_double ? plt_gain_t'({base[4:0], 1'b0}) : base;
  end
endmodule // plt_gain

//--- rtl/plt_top.sv
/*
 * Pixel level trim and dummy row sequencer: register port, dark level
 * offset with clamp, column gain and ramp slope outputs, black reference
 * columns, dummy row insertion on global transfer, output FIFO.
 * Assumes pixel samples and row strobes come from the converter front end
 * synchronous to i_clock, and a register port with write/read strobes.
 */
`timescale 1ns/1ps
`include "plt_defs.svh"
module plt_top
  import plt_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_dual_exposure,
  input wire logic i_xfer_level,
  input wire logic i_row_start,
  input wire logic i_pix_valid,
  input wire logic [`PLT_PIX_W-1:0] i_pix_data,
  input wire logic i_pix_ready,
  output logic o_pix_valid,
  output logic [`PLT_PIX_W-1:0] o_pix_data,
  output logic o_line_valid,
  output logic o_in_ready,
  output logic [5:0] o_column_amp_gain,
  output logic [7:0] o_ramp_slope
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic xfer_sync_ff;  // Transfer synchronisation bit, only stored and read back
  logic [13:0] ofs_ff;  // Dark level offset
  logic [1:0] col_gain_ff;  // Column amp gain code
  logic [7:0] ramp_ff;  // Ramp slope gain
  logic [7:0] dummy_ff;  // Dummy row count
  logic gain_dbl_ff;  // Gain doubling select
  logic black_en_ff;  // Black reference enable

  // Register writes
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      xfer_sync_ff <= 1'b0;
      ofs_ff <= `PLT_RST_OFS;
      col_gain_ff <= 2'h0;
      ramp_ff <= `PLT_RST_RAMP;
      dummy_ff <= `PLT_RST_DUMMY;
      gain_dbl_ff <= 1'b0;
      black_en_ff <= 1'b0;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `PLT_ADDR_XFER_SYNC: xfer_sync_ff <= i_reg_wdata[`PLT_BIT_XFER_SYNC];
        `PLT_ADDR_OFS_LO: ofs_ff[7:0] <= i_reg_wdata;
        `PLT_ADDR_OFS_HI: ofs_ff[13:8] <= i_reg_wdata[5:0];
        `PLT_ADDR_COL_GAIN: col_gain_ff <= i_reg_wdata[1:0];
        `PLT_ADDR_RAMP: ramp_ff <= i_reg_wdata;
        `PLT_ADDR_DUMMY: dummy_ff <= i_reg_wdata;
        `PLT_ADDR_EXTRA: begin
          gain_dbl_ff <= i_reg_wdata[`PLT_BIT_GAIN_DBL];
          black_en_ff <= i_reg_wdata[`PLT_BIT_BLACK_EN];
        end
        default: ;  // Unmapped writes ignored
      endcase
    end
  end

  // Register read data, registered
  logic [7:0] nxt_rdata;
  always_comb begin
    case (i_reg_addr)
      `PLT_ADDR_XFER_SYNC: nxt_rdata = {5'h00, xfer_sync_ff, 2'h0};
      `PLT_ADDR_OFS_LO: nxt_rdata = ofs_ff[7:0];
      `PLT_ADDR_OFS_HI: nxt_rdata = {2'h0, ofs_ff[13:8]};
      `PLT_ADDR_COL_GAIN: nxt_rdata = {6'h00, col_gain_ff};
      `PLT_ADDR_RAMP: nxt_rdata = ramp_ff;
      `PLT_ADDR_DUMMY: nxt_rdata = dummy_ff;
      `PLT_ADDR_EXTRA: nxt_rdata = {6'h00, black_en_ff, gain_dbl_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge i_clock) begin
    if (!i_nrst) o_reg_rdata <= 8'h00;
    else if (i_reg_rd) o_reg_rdata <= nxt_rdata;
  end

  // ****************************************************************
  // Gain settings
  // ****************************************************************
  plt_gain_t gain_val;
  plt_gain u_gain (
    .i_code(col_gain_ff),
    .i_double(gain_dbl_ff),
    .o_gain(gain_val)
  );
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_column_amp_gain <= 6'h0A;
      o_ramp_slope <= `PLT_RST_RAMP;
    end else begin
      o_column_amp_gain <= gain_val;
      o_ramp_slope <= ramp_ff;
    end
  end

  // ****************************************************************
  // Dummy row sequencer
  // ****************************************************************
  plt_state_t state_ff;  // Sequencer state
  logic [7:0] left_ff;  // Dummy rows still to insert
  logic xfer_d_ff;  // Previous transfer level
  logic pend_ff;  // Transfer seen, dummies owed
  logic xfer_edge;
  // Rising edge always; falling edge too under dual exposure
  assign xfer_edge = (i_xfer_level && !xfer_d_ff) ||
                     (i_dual_exposure && !i_xfer_level && xfer_d_ff);

  always_ff @(posedge i_clock) begin
    if (!i_nrst) xfer_d_ff <= 1'b0;
    else xfer_d_ff <= i_xfer_level;
  end

  // Pending dummy request; a new edge wins over consumption
  always_ff @(posedge i_clock) begin
    if (!i_nrst) pend_ff <= 1'b0;
    else if (xfer_edge && dummy_ff != 8'h00) pend_ff <= 1'b1;
    else if (i_row_start && state_ff != PLT_DUMMY) pend_ff <= 1'b0;
  end

  // Row state: each row start begins a data row or a dummy row
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_ff <= PLT_IDLE;
      left_ff <= 8'h00;
    end else if (i_row_start) begin
      case (state_ff)
        PLT_DUMMY: begin
          if (left_ff > 8'h01) begin
            left_ff <= left_ff - 8'h01;
          end else begin
            left_ff <= 8'h00;
            state_ff <= PLT_ROW;
          end
        end
        default: begin
          if (pend_ff || (xfer_edge && dummy_ff != 8'h00)) begin
            state_ff <= PLT_DUMMY;
            left_ff <= dummy_ff;
          end else begin
            state_ff <= PLT_ROW;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Pixel datapath
  // ****************************************************************
  logic [11:0] col_ff;  // Column within row
  always_ff @(posedge i_clock) begin
    if (!i_nrst) col_ff <= 12'h000;
    else if (i_row_start) col_ff <= 12'h000;
    else if (i_pix_valid && o_in_ready && col_ff != 12'hFFF) col_ff <= col_ff + 12'h001;
  end

  logic signed [15:0] sum;
  logic [`PLT_PIX_W-1:0] trimmed;
  always_comb begin
    // Sign-extend 14-bit offset, add converter offset
    sum = $signed({4'h0, i_pix_data}) + `PLT_ADC_OFFSET +
          $signed({{2{ofs_ff[13]}}, ofs_ff});
    if (sum > `PLT_CODE_MAX) trimmed = 12'hFFF;
    else if (sum < `PLT_CODE_MIN) trimmed = 12'h000;
    else trimmed = sum[11:0];
    if (black_en_ff && col_ff < `PLT_BLACK_COLS) begin
      // Black reference: pixel signal removed, dark level only
      sum = `PLT_ADC_OFFSET + $signed({{2{ofs_ff[13]}}, ofs_ff});
      if (sum > `PLT_CODE_MAX) trimmed = 12'hFFF;
      else if (sum < `PLT_CODE_MIN) trimmed = 12'h000;
      else trimmed = sum[11:0];
    end
  end

  logic in_row;
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_push;  // Sample accepted into the FIFO
  logic fifo_pop;  // Entry moved to the output register
  logic [`PLT_PIX_W-1:0] fifo_data;
  // Dummy rows produce no samples into the FIFO and release none from it
  assign in_row = (state_ff == PLT_ROW);
  // Only samples offered while ready was shown are taken
  assign fifo_push = i_pix_valid && in_row && o_in_ready;
  assign fifo_pop = fifo_valid && i_pix_ready && in_row;
  plt_fifo #(
    .WIDTH(`PLT_PIX_W),
    .DEPTH(`PLT_FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_valid(fifo_push),
    .o_ready(fifo_in_ready),
    .i_data(trimmed),
    .o_valid(fifo_valid),
    .i_ready(i_pix_ready && in_row),
    .o_data(fifo_data)
  );
  // Ready is registered, so it drops for one cycle after every cycle in which
  // the FIFO level rises; a sample offered in a data row while ready shows is never lost
  always_ff @(posedge i_clock) begin
    if (!i_nrst) o_in_ready <= 1'b0;
    else o_in_ready <= fifo_in_ready && !(fifo_push && !fifo_pop);
  end

  // Output stage register
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_pix_valid <= 1'b0;
      o_pix_data <= 12'h000;
    end else if (!o_pix_valid || i_pix_ready) begin
      o_pix_valid <= fifo_pop;
      o_pix_data <= fifo_data;
    end
  end

  // Line valid held low in dummy rows, from one cycle after the row start
  always_ff @(posedge i_clock) begin
    if (!i_nrst) o_line_valid <= 1'b0;
    else o_line_valid <= in_row;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  dummy_lv_low_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    state_ff == PLT_DUMMY |=> !o_line_valid)
    else $error("line valid high in dummy row");
  dummy_entry_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_row_start && state_ff != PLT_DUMMY && pend_ff) |=> state_ff == PLT_DUMMY)
    else $error("dummy rows not inserted");
  zero_count_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (dummy_ff == 8'h00 && !pend_ff && state_ff != PLT_DUMMY) |=> state_ff != PLT_DUMMY)
    else $error("dummy row with zero count");
  gain_map_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (col_gain_ff == 2'h1 && !gain_dbl_ff) ##1 $stable(col_gain_ff) && !gain_dbl_ff
    |=> o_column_amp_gain == 5'h0C)
    else $error("gain code 1 not x1.2");
  gain_dbl_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    gain_dbl_ff |-> gain_val == 6'(2 * (10 + 2 * col_gain_ff)))
    else $error("gain not doubled");
  ramp_follow_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    $changed(ramp_ff) |=> o_ramp_slope == $past(ramp_ff))
    else $error("ramp slope not applied");
  trim_value_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (!black_en_ff && ofs_ff == 14'h3FC3 && i_pix_data == 12'h000) |-> trimmed == 12'h009)
    else $error("dark level not 70 plus offset");
  offset_neg_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (ofs_ff == 14'h2000) |-> trimmed == 12'h000)
    else $error("offset sign or clamp wrong");
  clamp_high_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (!black_en_ff && i_pix_data == 12'hFFF && !ofs_ff[13]) |-> trimmed == 12'hFFF)
    else $error("sum wrapped instead of clamping");
  black_col_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (black_en_ff && col_ff < `PLT_BLACK_COLS && ofs_ff == 14'h0000) |-> trimmed == 12'h046)
    else $error("black column carries pixel data");
  dual_edge_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (i_dual_exposure && $fell(i_xfer_level) && dummy_ff != 8'h00 && !i_row_start)
    |=> pend_ff)
    else $error("falling toggle did not request dummies");
endmodule // plt_top

//--- verification/plt_sink.sv
/*
 * Frame grabber model that takes trimmed pixels from the block.
 * Assumes one clock; ready changes 1 ns after each rising edge.
 */
`timescale 1ns/1ps
module plt_sink (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic [11:0] i_data,
  output logic o_ready,
  output logic o_got,
  output logic [11:0] o_data
);
  integer seed; // Stall pattern seed
  initial begin
    seed = 32'hBE45;
    o_ready = 1'b0;
    o_got = 1'b0;
    o_data = 12'h000;
  end
  // Take a pixel only when the strobe says so; stall one cycle in four
  always @(posedge i_clock) begin
    o_got <= i_nrst && i_valid && o_ready;
    o_data <= i_data;
    #1;
    o_ready = ($random(seed) & 3) != 0;
  end
endmodule // plt_sink

//--- verification/pixel_level_trim_and_dummy_rows_test.sv
/*
 * Self-checking bench: register port, gain and ramp outputs, trimmed
 * pixel stream and dummy row insertion, against a queue-based model.
 * Assumes plt_defs.svh on the include path and the plt_sink model.
 */
`timescale 1ns/1ps
`include "plt_defs.svh"
module pixel_level_trim_and_dummy_rows_test;
  logic clock = 1'b0;
  logic nrst, reg_wr, reg_rd, dual, xfer, row_start, pix_valid, pix_ready;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ramp;
  logic [11:0] pix_data, out_data, got_data;
  logic out_valid, line_valid, in_ready, got;
  logic [5:0] gain;
  int err_total, checked, cycles, ofs, dummy_n, dummy_left;
  bit black, pend;
  integer seed;
  logic [11:0] exp_q[$]; // Expected pixels in order
  int offs[5] = '{-61, 8191, -8192, 0, 1000};

  plt_top uut (.i_clock(clock), .i_nrst(nrst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_dual_exposure(dual), .i_xfer_level(xfer), .i_row_start(row_start),
    .i_pix_valid(pix_valid), .i_pix_data(pix_data), .i_pix_ready(pix_ready),
    .o_pix_valid(out_valid), .o_pix_data(out_data), .o_line_valid(line_valid),
    .o_in_ready(in_ready), .o_column_amp_gain(gain), .o_ramp_slope(ramp));
  plt_sink sink (.i_clock(clock), .i_nrst(nrst), .i_valid(out_valid), .i_data(out_data),
    .o_ready(pix_ready), .o_got(got), .o_data(got_data));

  // ****************************************************************
  // Clock, timeout and checking helpers
  // ****************************************************************
  initial begin
    forever #2.5 clock = ~clock;
  end
  task end_of_test;
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 6000) begin
      err_total++;
      $display("BAD %0t run hung", $time);
      end_of_test();
    end
  end
  task chk_reg(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t byte got %h exp %h", $time, g, e);
    end
  endtask
  task chk_pix(input logic [11:0] g, input logic [11:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t pixel got %h exp %h", $time, g, e);
    end
  endtask
  task chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  // Dark level model: converter offset plus signed trim, clamped to 12 bits
  function logic [11:0] trim(input int pix);
    int s;
    s = pix + 70 + ofs;
    if (s > 4095) s = 4095;
    if (s < 0) s = 0;
    return s[11:0];
  endfunction
  // Every pixel taken by the far side must be the next expected one
  always @(negedge clock) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_pix(got_data, exp_q.pop_front());
    end
  end

  // ****************************************************************
  // Register port and stream drivers
  // ****************************************************************
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock); #1;
    reg_wr = 1'b0;
    // One idle edge, so a following write never re-raises the strobe at once
    @(posedge clock); #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock); #1;
    reg_rd = 1'b0;
    chk_reg(reg_rdata, e);
    @(posedge clock); #1;
  endtask
  task set_ofs(input int v);
    logic [13:0] t;
    t = v[13:0];
    wr(`PLT_ADDR_OFS_LO, t[7:0]);
    wr(`PLT_ADDR_OFS_HI, {2'h0, t[13:8]});
    ofs = v;
  endtask
  // Transfer level change; an event arms the dummy rows if a count is set
  task set_xfer(input logic lvl);
    if (((lvl && !xfer) || (!lvl && xfer && dual)) && dummy_n != 0) pend = 1;
    xfer = lvl;
    repeat (3) @(posedge clock);
    #1;
  endtask
  // One row slot; samples in dummy rows are sent and must be dropped
  task do_row(input int npix);
    int col;
    bit dmy;
    logic v;
    if (pend && dummy_left == 0) begin
      dummy_left = dummy_n;
      pend = 0;
    end
    dmy = dummy_left > 0;
    if (dmy) dummy_left--;
    col = 0;
    row_start = 1'b1;
    @(posedge clock); #1;
    row_start = 1'b0;
    for (int i = 0; i < npix + 8; i++) begin
      v = (i < npix) && (($random(seed) & 3) != 0);
      pix_valid = v;
      pix_data = $random(seed);
      if (v && in_ready === 1'b1 && !dmy) begin
        exp_q.push_back((black && col < 16) ? trim(0) : trim(int'(pix_data)));
        col++;
      end
      @(posedge clock); #1;
      if (i == 1) chk_bit(line_valid, !dmy);
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'hBE45;
    {nrst, reg_wr, reg_rd, dual, xfer, row_start, pix_valid} = 7'h00;
    {reg_addr, reg_wdata, pix_data} = 28'h0000000;
    ofs = -61;
    {black, pend} = 2'b00;
    dummy_n = 0;
    dummy_left = 0;
    repeat (4) @(posedge clock);
    #1 nrst = 1'b1;
    chk_reg({2'h0, gain}, 8'h0A);
    chk_reg(ramp, 8'h20);
    rd(`PLT_ADDR_XFER_SYNC, 8'h00);
    rd(`PLT_ADDR_OFS_LO, 8'hC3);
    rd(`PLT_ADDR_OFS_HI, 8'h3F);
    rd(`PLT_ADDR_COL_GAIN, 8'h00);
    rd(`PLT_ADDR_RAMP, 8'h20);
    rd(`PLT_ADDR_DUMMY, 8'h00);
    rd(`PLT_ADDR_EXTRA, 8'h00);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 4; c++) begin
        wr(`PLT_ADDR_EXTRA, d[7:0]);
        wr(`PLT_ADDR_COL_GAIN, {6'h3F, c[1:0]});
        @(posedge clock); #1;
        chk_reg({2'h0, gain}, 8'((10 + 2 * c) * (d + 1)));
      end
    end
    rd(`PLT_ADDR_COL_GAIN, 8'h03);
    rd(`PLT_ADDR_EXTRA, 8'h01);
    for (int k = 0; k < 3; k++) begin
      reg_wdata = $random(seed);
      wr(`PLT_ADDR_RAMP, reg_wdata);
      @(posedge clock); #1;
      chk_reg(ramp, reg_wdata);
      rd(`PLT_ADDR_RAMP, reg_wdata);
    end
    foreach (offs[k]) begin
      set_ofs(offs[k]);
      do_row(24);
    end
    rd(`PLT_ADDR_OFS_HI, 8'h03);
    set_ofs(0);
    wr(`PLT_ADDR_EXTRA, 8'h02);
    black = 1;
    do_row(24);
    wr(`PLT_ADDR_EXTRA, 8'h00);
    black = 0;
    wr(`PLT_ADDR_XFER_SYNC, 8'hFF);
    rd(`PLT_ADDR_XFER_SYNC, 8'h04);
    wr(`PLT_ADDR_DUMMY, 8'h02);
    dummy_n = 2;
    do_row(20);
    set_xfer(1'b1);
    repeat (4) do_row(20);
    dual = 1'b1;
    set_xfer(1'b0);
    repeat (3) do_row(20);
    dual = 1'b0;
    wr(`PLT_ADDR_DUMMY, 8'h00);
    dummy_n = 0;
    set_xfer(1'b1);
    do_row(20);
    wr(`PLT_ADDR_DUMMY, 8'h01);
    dummy_n = 1;
    set_xfer(1'b0);
    do_row(20);
    repeat (30) @(posedge clock);
    chk_bit(exp_q.size() == 0, 1'b1);
    end_of_test();
  end
endmodule // pixel_level_trim_and_dummy_rows_test
